// ===== core/clock_gen_pkg.sv
// constants shared by the stretchable clock generator files
// assumes a single 250 mhz core clock; frequency sources arrive as sampled pins
package clock_gen_pkg;
  localparam int CORE_CLK_KHZ = 250000;
  localparam int POWERUP_HOLD_MS = 30;
  localparam int POWERUP_HOLD_CYCLES = POWERUP_HOLD_MS * CORE_CLK_KHZ;
  localparam int RESET_HOLD_SYS_CYCLES = 16;
  localparam int STRETCH_WIDTH = 2;
  localparam int SYNC_WIDTH = 8;
  // synchronised input bit positions
  localparam int SYNC_SYS_SRC = 0;
  localparam int SYNC_GP_SRC = 1;
  localparam int SYNC_HOLD = 2;
  localparam int SYNC_INHIBIT = 3;
  localparam int SYNC_SEL1 = 4;
  localparam int SYNC_SEL2 = 5;
  localparam int SYNC_START = 6;
  localparam int SYNC_RST_REQ = 7;
  // all pins but the two frequency sources idle high
  localparam logic [SYNC_WIDTH-1:0] SYNC_RESET_VALUE = 8'hfc;
  localparam logic [1:0] COUNT_RESET_VALUE = 2'h0;
  localparam logic [2:0] EDGE_LIMIT = 3'h4;
endpackage : clock_gen_pkg

// ===== core/pin_sync.sv
// two-flop synchroniser for a group of asynchronous pins
// assumes every bit is a level from outside the core clock domain
`timescale 1ns/100ps
module pin_sync #(
  parameter int WIDTH = 8,
  parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] sync_reg;

  initial
  begin
    if (WIDTH < 1)
    begin
      $error("pin_sync width must be at least one");
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      meta_reg <= RESET_VALUE;
      sync_reg <= RESET_VALUE;
    end
    else
    begin
      meta_reg <= async_in;
      sync_reg <= meta_reg;
    end
  end

  assign sync_out = sync_reg;
endmodule : pin_sync

// ===== core/stretchable_clock_generator.sv
// stretchable system clock, time base, general clock, edge counter and reset output
// assumes both frequency sources are well below a quarter of the core clock rate
// Notes on behaviour
// - unstretched, the system clock runs at half the system source frequency.
// - the time base follows the system source frequency, never stretched.
// - the general clock runs at half the general source frequency, untouched by stretch.
// - a selected half-cycle of the system clock grows by one to three whole source periods.
// - both delay selects are sampled at a time base rising edge and set the added periods.
// - hold low means unlimited, else inhibit low adds 0, else selects give 3, 2, 1 or 0.
// - while inhibit is low the delay selects are ignored.
// - while hold is low the current half-cycle stays extended.
// - hold overrides inhibit and both delay selects.
// - a falling start edge clears the two-bit counter and lets it count system clock rises.
// - after the start the counter follows the next four system clock rising edges.
// - the count outputs show, in binary, the rising edges seen since the start.
// - a low reset request asserts the reset output in step with the clock; power-up holds it low from reset.
// - the reset output falls at the next system clock rise and stays low 16 clock cycles.
// - after power-up the reset output stays low at least 30 ms.
`timescale 1ns/100ps
module stretchable_clock_generator #(
  parameter int POWERUP_CYCLES = clock_gen_pkg::POWERUP_HOLD_CYCLES
) (
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  input wire logic system_source_in,
  input wire logic general_source_in,
  input wire logic delay_select_1_n_in,
  input wire logic delay_select_2_n_in,
  input wire logic delay_inhibit_n_in,
  input wire logic hold_stretch_n_in,
  input wire logic count_start_fall_in,
  input wire logic reset_request_in_n_in,
  output logic system_clock_out,
  output logic time_base_out,
  output logic general_clock_out,
  output logic edge_count_bit0_out,
  output logic edge_count_bit1_out,
  output logic system_reset_out_n_out
);
  localparam int PU_WIDTH = $clog2(POWERUP_CYCLES + 1);

  initial
  begin
    if (POWERUP_CYCLES < 1)
    begin
      $error("power-up hold must be at least one cycle");
    end
  end

  typedef enum logic [3:0] {
    RST_POWERUP = 4'h1,
    RST_IDLE = 4'h2,
    RST_PENDING = 4'h4,
    RST_HOLD = 4'h8
  } reset_state_type;

  logic [clock_gen_pkg::SYNC_WIDTH-1:0] pins_async;
  logic [clock_gen_pkg::SYNC_WIDTH-1:0] pins;

  assign pins_async = {reset_request_in_n_in, count_start_fall_in, delay_select_2_n_in,
                       delay_select_1_n_in, delay_inhibit_n_in, hold_stretch_n_in,
                       general_source_in, system_source_in};

  pin_sync #(
    .WIDTH(clock_gen_pkg::SYNC_WIDTH),
    .RESET_VALUE(clock_gen_pkg::SYNC_RESET_VALUE)
  ) u_pin_sync (
    .core_clk_in(core_clk_in),
    .rst_n_in(rst_n_in),
    .async_in(pins_async),
    .sync_out(pins)
  );

  // decoded added periods; hold is handled separately as unlimited
  function automatic logic [1:0] added_periods(input logic inh_n, input logic s2_n,
                                               input logic s1_n);
    logic [1:0] n;
    n = 2'h0;
    if (inh_n)
    begin
      n = {~s2_n, ~s1_n};
    end
    return n;
  endfunction : added_periods

  logic sys_src_prev_reg, sys_src_prev_next;
  logic gp_src_prev_reg, gp_src_prev_next;
  logic start_prev_reg, start_prev_next;
  logic sysclk_reg, sysclk_next;
  logic time_base_reg, time_base_next;
  logic gpclk_reg, gpclk_next;
  logic [clock_gen_pkg::STRETCH_WIDTH-1:0] stretch_reg, stretch_next;
  logic [1:0] count_reg, count_next;
  logic [2:0] edges_reg, edges_next;
  logic count_en_reg, count_en_next;
  reset_state_type rst_state_reg, rst_state_next;
  logic [PU_WIDTH-1:0] pu_cnt_reg, pu_cnt_next;
  logic [4:0] hold_cnt_reg, hold_cnt_next;
  logic rst_out_n_reg, rst_out_n_next;

  logic sys_tick;
  logic gp_tick;
  logic sys_rise;
  logic start_fall;

  assign sys_tick = pins[clock_gen_pkg::SYNC_SYS_SRC] & ~sys_src_prev_reg;
  assign gp_tick = pins[clock_gen_pkg::SYNC_GP_SRC] & ~gp_src_prev_reg;
  assign start_fall = ~pins[clock_gen_pkg::SYNC_START] & start_prev_reg;

  // clock paths and stretch
  always_comb
  begin
    sys_src_prev_next = pins[clock_gen_pkg::SYNC_SYS_SRC];
    gp_src_prev_next = pins[clock_gen_pkg::SYNC_GP_SRC];
    time_base_next = pins[clock_gen_pkg::SYNC_SYS_SRC];
    gpclk_next = gpclk_reg;
    sysclk_next = sysclk_reg;
    stretch_next = stretch_reg;
    sys_rise = 1'b0;
    if (gp_tick)
    begin
      gpclk_next = ~gpclk_reg;
    end
    if (sys_tick)
    begin
      if (!pins[clock_gen_pkg::SYNC_HOLD])
      begin
        sysclk_next = sysclk_reg;
      end
      else if (stretch_reg != 2'h0)
      begin
        stretch_next = stretch_reg - 2'h1;
      end
      else
      begin
        // one toggle per source period at most keeps edges clean
        sysclk_next = ~sysclk_reg;
        sys_rise = ~sysclk_reg;
        stretch_next = added_periods(pins[clock_gen_pkg::SYNC_INHIBIT],
                                     pins[clock_gen_pkg::SYNC_SEL2],
                                     pins[clock_gen_pkg::SYNC_SEL1]);
      end
    end
  end

  // edge counter
  always_comb
  begin
    start_prev_next = pins[clock_gen_pkg::SYNC_START];
    count_next = count_reg;
    edges_next = edges_reg;
    count_en_next = count_en_reg;
    if (start_fall)
    begin
      count_next = clock_gen_pkg::COUNT_RESET_VALUE;
      edges_next = 3'h0;
      count_en_next = 1'b1;
    end
    else if (count_en_reg && sys_rise)
    begin
      count_next = count_reg + 2'h1;
      edges_next = edges_reg + 3'h1;
      if (edges_reg + 3'h1 == clock_gen_pkg::EDGE_LIMIT)
      begin
        count_en_next = 1'b0;
      end
    end
  end

  // reset output sequencing
  always_comb
  begin
    rst_state_next = rst_state_reg;
    pu_cnt_next = pu_cnt_reg;
    hold_cnt_next = hold_cnt_reg;
    rst_out_n_next = rst_out_n_reg;
    case (rst_state_reg)
      RST_POWERUP:
      begin
        rst_out_n_next = 1'b0;
        if (pu_cnt_reg >= PU_WIDTH'(POWERUP_CYCLES - 1))
        begin
          // release waits for a clock rise so the edge stays synchronous
          if (sys_rise)
          begin
            rst_out_n_next = 1'b1;
            rst_state_next = RST_IDLE;
          end
        end
        else
        begin
          pu_cnt_next = pu_cnt_reg + PU_WIDTH'(1);
        end
      end
      RST_IDLE:
      begin
        if (!pins[clock_gen_pkg::SYNC_RST_REQ])
        begin
          rst_state_next = RST_PENDING;
        end
      end
      RST_PENDING:
      begin
        if (sys_rise)
        begin
          rst_out_n_next = 1'b0;
          hold_cnt_next = 5'h0;
          rst_state_next = RST_HOLD;
        end
      end
      RST_HOLD:
      begin
        if (sys_rise)
        begin
          hold_cnt_next = hold_cnt_reg + 5'h1;
          if (hold_cnt_reg == 5'(clock_gen_pkg::RESET_HOLD_SYS_CYCLES - 1))
          begin
            rst_out_n_next = 1'b1;
            // a request still held low starts another period
            rst_state_next = RST_IDLE;
          end
        end
      end
      default:
      begin
        rst_state_next = RST_POWERUP;
        rst_out_n_next = 1'b0;
      end
    endcase
  end

  always_ff @(posedge core_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      sys_src_prev_reg <= 1'b0;
      gp_src_prev_reg <= 1'b0;
      start_prev_reg <= 1'b1;
      sysclk_reg <= 1'b0;
      time_base_reg <= 1'b0;
      gpclk_reg <= 1'b0;
      stretch_reg <= 2'h0;
      count_reg <= clock_gen_pkg::COUNT_RESET_VALUE;
      edges_reg <= 3'h0;
      count_en_reg <= 1'b0;
      rst_state_reg <= RST_POWERUP;
      pu_cnt_reg <= '0;
      hold_cnt_reg <= 5'h0;
      rst_out_n_reg <= 1'b0;
    end
    else
    begin
      sys_src_prev_reg <= sys_src_prev_next;
      gp_src_prev_reg <= gp_src_prev_next;
      start_prev_reg <= start_prev_next;
      sysclk_reg <= sysclk_next;
      time_base_reg <= time_base_next;
      gpclk_reg <= gpclk_next;
      stretch_reg <= stretch_next;
      count_reg <= count_next;
      edges_reg <= edges_next;
      count_en_reg <= count_en_next;
      rst_state_reg <= rst_state_next;
      pu_cnt_reg <= pu_cnt_next;
      hold_cnt_reg <= hold_cnt_next;
      rst_out_n_reg <= rst_out_n_next;
    end
  end

  assign system_clock_out = sysclk_reg;
  assign time_base_out = time_base_reg;
  assign general_clock_out = gpclk_reg;
  assign edge_count_bit0_out = count_reg[0];
  assign edge_count_bit1_out = count_reg[1];
  assign system_reset_out_n_out = rst_out_n_reg;
endmodule : stretchable_clock_generator

// ===== tb/clk_gen_chk.sv
// checker for the stretchable clock generator ports
// assumes a bind by port name and the three flop input delay
`timescale 1ns/100ps
module clk_gen_chk #(
  parameter int POWERUP_CYCLES = 20
) (
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  input wire logic system_source_in,
  input wire logic general_source_in,
  input wire logic hold_stretch_n_in,
  input wire logic count_start_fall_in,
  input wire logic system_clock_out,
  input wire logic time_base_out,
  input wire logic general_clock_out,
  input wire logic edge_count_bit0_out,
  input wire logic edge_count_bit1_out,
  input wire logic system_reset_out_n_out
);
  default clocking @(posedge core_clk_in);
  endclocking
  default disable iff (!rst_n_in);
  logic [3:0] src_d, gen_d, hold_d, start_d, lows_reg;
  logic [31:0] age_reg;
  logic pu_reg, on_reg, sys_d, rst_d;
  logic [1:0] cnt_d;
  wire [1:0] cnt = {edge_count_bit1_out, edge_count_bit0_out};
  wire ok = age_reg > 32'h5;
  wire sys_rise = system_clock_out & ~sys_d;
  wire start_fell = ok & ~start_d[2] & start_d[3];
  always_ff @(posedge core_clk_in)
  begin
    src_d <= {src_d[2:0], system_source_in};
    gen_d <= {gen_d[2:0], general_source_in};
    hold_d <= {hold_d[2:0], hold_stretch_n_in};
    start_d <= {start_d[2:0], count_start_fall_in};
    sys_d <= system_clock_out;
    rst_d <= system_reset_out_n_out;
    cnt_d <= cnt;
  end
  always_ff @(posedge core_clk_in or negedge rst_n_in)
    if (!rst_n_in)
    begin
      age_reg <= '0;
      pu_reg <= 1'b1;
      on_reg <= 1'b0;
      lows_reg <= '0;
    end
    else
    begin
      age_reg <= age_reg + 32'h1;
      if (system_reset_out_n_out)
        pu_reg <= 1'b0;
      if (start_fell)
        on_reg <= 1'b1;
      else if (sys_rise && cnt == 2'h0)
        on_reg <= 1'b0;
      if (rst_d && !system_reset_out_n_out)
        lows_reg <= '0;
      else if (sys_rise && !system_reset_out_n_out)
        lows_reg <= lows_reg + 4'h1;
    end
  sequence gen_tick;
    gen_d[2] && !gen_d[3];
  endsequence
  chk_tb_follow: assert property (ok |-> time_base_out == src_d[2])
    else $error("time base lags wrongly");
  chk_sys_edge: assert property (ok && $changed(system_clock_out)
    |-> $rose(time_base_out))
    else $error("system clock edge off time base");
  chk_gen_tick: assert property (ok && $changed(general_clock_out) |-> gen_tick)
    else $error("general clock edge without tick");
  chk_hold_freeze: assert property (ok && !hold_d[2] |-> $stable(system_clock_out))
    else $error("clock moved during hold");
  chk_count_step: assert property (ok && sys_rise && on_reg && !start_fell
    |-> cnt == cnt_d + 2'h1)
    else $error("count step wrong");
  chk_rst_sync: assert property (ok && $changed(system_reset_out_n_out) |-> sys_rise)
    else $error("reset out not on clock rise");
  chk_rst_len: assert property ($rose(system_reset_out_n_out) && !pu_reg
    |-> lows_reg == 4'hf)
    else $error("reset out length wrong");
  chk_pu_hold: assert property ($rose(system_reset_out_n_out) && pu_reg
    |-> age_reg >= POWERUP_CYCLES)
    else $error("power-up hold too short");
endmodule : clk_gen_chk
bind stretchable_clock_generator clk_gen_chk #(.POWERUP_CYCLES(POWERUP_CYCLES)) i_clk_gen_chk (.*);

// ===== tb/src_model.sv
// model of the two external frequency sources
// assumes a 4 ns core clock; both sources stay under a quarter of its rate
`timescale 1ns/100ps
module src_model #(
  parameter real SYS_HALF_NS = 16.3,
  parameter real GEN_HALF_NS = 22.7
) (
  output logic system_source_out,
  output logic general_source_out
);
  initial system_source_out = 1'b0;
  initial general_source_out = 1'b0;
  // odd half periods keep the phase drifting against the core clock
  always #(SYS_HALF_NS) system_source_out = ~system_source_out;
  always #(GEN_HALF_NS) general_source_out = ~general_source_out;
endmodule : src_model

// ===== tb/tb_top.sv
// self-checking bench for the stretchable clock generator
// assumes the source model and the bound checker
`timescale 1ns/100ps
module tb_top;
  logic core_clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic system_source_in;
  logic general_source_in;
  logic delay_select_1_n_in = 1'b1;
  logic delay_select_2_n_in = 1'b1;
  logic delay_inhibit_n_in = 1'b1;
  logic hold_stretch_n_in = 1'b1;
  logic count_start_fall_in = 1'b1;
  logic reset_request_in_n_in = 1'b1;
  logic system_clock_out, time_base_out, general_clock_out;
  logic edge_count_bit0_out, edge_count_bit1_out, system_reset_out_n_out;
  int bad_count = 0;
  int tests_run = 0;
  int len_q[$];
  logic [1:0] cnt_q[$];
  int rises = 0;
  int n;
  logic sys_last = 1'b0;
  logic tb_last = 1'b0;
  logic held;
  event tog;
  always #2 core_clk_in = ~core_clk_in;
  src_model i_src_model (.system_source_out(system_source_in),
    .general_source_out(general_source_in));
  stretchable_clock_generator #(.POWERUP_CYCLES(20)) i_stretchable_clock_generator (.*);
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("BAD %0t saw %0h want %0h", $time, seen, exp);
    end
  endtask : check
  task automatic results();
    if (bad_count == 0 && tests_run > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : results
  // c is {inhibit, select 2, select 1}; two toggles let the controls settle
  task automatic stretch(input logic [2:0] c);
    {delay_inhibit_n_in, delay_select_2_n_in, delay_select_1_n_in} = c;
    repeat (2) @tog;
    len_q.push_back(c[2] ? 4 - int'(c[1:0]) : 1);
  endtask : stretch
  always @(negedge core_clk_in)
  begin
    if (time_base_out && !tb_last)
      rises++;
    if (system_clock_out !== sys_last)
    begin
      if (len_q.size() > 0)
        check(8'(rises), 8'(len_q.pop_front()));
      if (system_clock_out && cnt_q.size() > 0)
        check({6'h0, edge_count_bit1_out, edge_count_bit0_out},
              {6'h0, cnt_q.pop_front()});
      rises = 0;
      -> tog;
    end
    tb_last = time_base_out;
    sys_last = system_clock_out;
  end
  initial
  begin
    #100000;
    bad_count++;
    results();
  end
  initial
  begin
    void'($urandom(32'h206b));
    repeat (10) @(negedge core_clk_in);
    rst_n_in = 1'b1;
    repeat (10) @(negedge core_clk_in);
    check(8'(system_reset_out_n_out), 8'h0);
    n = 0;
    while (system_reset_out_n_out !== 1'b1 && n < 100)
    begin
      @(negedge core_clk_in);
      n++;
    end
    check(8'(system_reset_out_n_out), 8'h1);
    for (int i = 0; i < 12; i++)
      stretch(i < 8 ? 3'(i) : 3'($urandom));
    repeat (2) @tog;
    {delay_inhibit_n_in, delay_select_2_n_in, delay_select_1_n_in} = 3'h0;
    hold_stretch_n_in = 1'b0;
    repeat (8) @(negedge core_clk_in);
    held = system_clock_out;
    repeat (60) @(negedge core_clk_in);
    check(8'(system_clock_out), 8'(held));
    hold_stretch_n_in = 1'b1;
    // start drops just after a fall so no rise races the clear
    do
      @tog;
    while (system_clock_out !== 1'b0);
    count_start_fall_in = 1'b0;
    cnt_q = '{2'h1, 2'h2, 2'h3, 2'h0, 2'h0};
    repeat (12) @tog;
    count_start_fall_in = 1'b1;
    reset_request_in_n_in = 1'b0;
    repeat (4) @(negedge core_clk_in);
    reset_request_in_n_in = 1'b1;
    n = 0;
    while (system_reset_out_n_out !== 1'b0 && n < 8)
    begin
      @tog;
      n++;
    end
    n = 0;
    while (system_reset_out_n_out === 1'b0 && n < 40)
    begin
      @tog;
      n += int'(system_clock_out);
    end
    check(8'(n), 8'h10);
    results();
  end
endmodule : tb_top
